// ### rx_mon_defs.svh
// Constants of the receive range monitor, link fault and self-test checker.
`ifndef RX_MON_DEFS_SVH
`define RX_MON_DEFS_SVH
`define RC_LAST_CYC     12'hFFF
`define RC_EXP_FULL     13'h1000
`define RC_EXP_HALF     13'h0800
`define RC_TOL_FULL     13'h0006
`define RC_TOL_HALF     13'h0003
`define RUN_LIMIT       3'h7
`define SPEED_LOW       2'h0
`define BIST_SEL_CHECK  2'h2
`define BIST_SEL_RESET  2'h3
`define BIST_ABORT_DIFF 5'h10
`define LFSR_SEED       9'h1FF
`define CODE_GOOD       3'h0
`define CODE_ERR        3'h1
`define CODE_WAIT       3'h3
`define CODE_LOOP_OK    3'h2
`define CODE_LOOP_ERR   3'h4
`endif

// ### rx_mon_pkg.sv
// Types of the receive range monitor, link fault and self-test checker.
package rx_mon_pkg;
  typedef enum logic [1:0] {
    BIST_OFF   = 2'b00,
    BIST_START = 2'b01,
    BIST_WAIT  = 2'b10,
    BIST_CMP   = 2'b11
  } bist_state_e;

  typedef struct packed {
    logic [11:0] rc_cnt;
    logic [12:0] tick_cnt;
    logic        force_trn;
    logic        en;
    logic [2:0]  run_cnt;
    logic        last_bit;
    logic [1:0]  bist_sel;
    bist_state_e bist_st;
    logic [4:0]  diff;
    logic        loop_err;
    logic        loop_hit;
    logic        link_ok;
    logic        pll_en;
    logic        drv1;
    logic        drv2;
    logic        reclk_en;
  } mon_s;

  typedef struct packed {
    logic [1:0]       cnt;
    logic [1:0][10:0] slot;
    logic             out_valid;
    logic             in_ready;
  } buf_s;
endpackage

// ### rx_bist_lfsr.sv
// Nine-bit LFSR that produces the 511-character self-test sequence.
`timescale 1ns/1ps
`default_nettype none
`include "rx_mon_defs.svh"
module rx_bist_lfsr (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_restart,
  input  wire logic       i_advance,
  output logic [9:0]      o_char,
  output logic            o_at_seed
);
  logic [8:0] state_q;
  logic [8:0] state_d;

  always_comb begin
    state_d = state_q;
    if (i_restart) begin
      state_d = `LFSR_SEED;
    end else if (i_advance) begin
      state_d = {state_q[7:0], state_q[8] ^ state_q[4]};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= `LFSR_SEED;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_char    = {^state_q, state_q};
  assign o_at_seed = (state_q == `LFSR_SEED);
endmodule // rx_bist_lfsr
`default_nettype wire

// ### rx_skid_buffer.sv
// Two-entry buffer between the checker and the parallel output port.
`timescale 1ns/1ps
`default_nettype none
module rx_skid_buffer (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_valid,
  input  wire logic [10:0] i_data,
  output logic             o_ready,
  output logic             o_valid,
  output logic [10:0]      o_data,
  input  wire logic        i_ready
);
  rx_mon_pkg::buf_s s_q;
  rx_mon_pkg::buf_s s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.out_valid && i_ready) begin
      s_d.slot[0] = s_q.slot[1];
      s_d.cnt     = s_q.cnt - 2'h1;
    end
    if (i_valid && s_q.in_ready) begin
      s_d.slot[s_d.cnt[0]] = i_data;
      s_d.cnt              = s_d.cnt + 2'h1;
    end
    s_d.out_valid = (s_d.cnt != 2'h0);
    s_d.in_ready  = (s_d.cnt != 2'h2);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.in_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ready = s_q.in_ready;
  assign o_valid = s_q.out_valid;
  assign o_data  = s_q.slot[0];
endmodule // rx_skid_buffer
`default_nettype wire

// ### rx_range_monitor_bist_checker.sv
// Receive range monitor, link fault, reclocker enables and self-test checker.
`timescale 1ns/1ps
`default_nettype none
`include "rx_mon_defs.svh"
module rx_range_monitor_bist_checker (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_rx_channel_power_enable,
  input  wire logic [1:0] i_rx_speed_select,
  input  wire logic       i_training_rate_select,
  input  wire logic       i_training_clock_tick,
  input  wire logic       i_pll_locked,
  input  wire logic [1:0] i_rx_selftest_field,
  input  wire logic       i_reclock_drv1_enable,
  input  wire logic       i_reclock_drv2_enable,
  input  wire logic [9:0] i_rx_char,
  input  wire logic       i_rx_char_valid,
  input  wire logic       i_out_ready,
  output logic            o_rx_char_ready,
  output logic            o_out_valid,
  output logic [9:0]      o_rx_data,
  output logic            o_selftest_status_bit,
  output logic            o_link_fault_n,
  output logic            o_vco_force_training,
  output logic            o_pll_enable,
  output logic            o_reclock_drv1_en,
  output logic            o_reclock_drv2_en,
  output logic            o_reclock_logic_en
);
  rx_mon_pkg::mon_s s_q;
  rx_mon_pkg::mon_s s_d;

  logic [9:0]  lfsr_char;
  logic        lfsr_at_seed;
  logic        lfsr_restart;
  logic        lfsr_advance;
  logic        buf_ready;
  logic        accept;
  logic        bist_on;
  logic        match;
  logic        reserved_cfg;
  logic        no_trans;
  logic [12:0] ticks;
  logic [12:0] expect_cnt;
  logic [12:0] tol_cnt;
  logic [12:0] dev_cnt;
  logic [2:0]  code;
  logic [10:0] out_word;

  assign accept       = i_rx_char_valid && buf_ready;
  assign bist_on      = (s_q.bist_sel == `BIST_SEL_CHECK);
  assign match        = (i_rx_char == lfsr_char);
  // Half-rate training at the lowest range has no valid clock; it is held as a fault.
  assign reserved_cfg = (i_rx_speed_select == `SPEED_LOW) && i_training_rate_select;
  assign ticks        = s_q.tick_cnt + {12'h000, i_training_clock_tick};
  assign expect_cnt   = i_training_rate_select ? `RC_EXP_HALF : `RC_EXP_FULL;
  assign tol_cnt      = i_training_rate_select ? `RC_TOL_HALF : `RC_TOL_FULL;
  assign dev_cnt      = (ticks > expect_cnt) ? ticks - expect_cnt : expect_cnt - ticks;
  assign no_trans     = (i_rx_char == {10{s_q.last_bit}});

  always_comb begin
    s_d          = s_q;
    lfsr_restart = 1'b0;
    lfsr_advance = 1'b0;
    code         = `CODE_WAIT;

    // Range control over a fixed window of recovered character periods.
    s_d.en = i_rx_channel_power_enable;
    if (!i_rx_channel_power_enable || !s_q.en) begin
      s_d.rc_cnt    = '0;
      s_d.tick_cnt  = '0;
      s_d.force_trn = 1'b0;
    end else if (s_q.rc_cnt == `RC_LAST_CYC) begin
      s_d.rc_cnt    = '0;
      s_d.tick_cnt  = '0;
      // The VCO stays on the training clock for a whole window, then is released only if that window was in range and not reserved.
      s_d.force_trn = (dev_cnt > tol_cnt) || reserved_cfg;
    end else begin
      s_d.rc_cnt   = s_q.rc_cnt + 12'h001;
      s_d.tick_cnt = ticks;
    end

    // Transition density, counted in whole characters.
    if (accept) begin
      s_d.last_bit = i_rx_char[9];
      if (no_trans) begin
        if (s_q.run_cnt != `RUN_LIMIT) begin
          s_d.run_cnt = s_q.run_cnt + 3'h1;
        end
      end else begin
        s_d.run_cnt = '0;
      end
    end
    if (!i_rx_channel_power_enable) begin
      s_d.run_cnt = '0;
    end

    s_d.link_ok = i_rx_channel_power_enable && i_pll_locked && !s_d.force_trn
                  && (s_d.run_cnt != `RUN_LIMIT) && !reserved_cfg;
    s_d.pll_en  = i_rx_channel_power_enable;

    // Reclocker drivers; the shared logic runs only while a driver is on.
    s_d.drv1     = i_reclock_drv1_enable;
    s_d.drv2     = i_reclock_drv2_enable;
    s_d.reclk_en = i_reclock_drv1_enable || i_reclock_drv2_enable;

    // Self-test checker.
    s_d.bist_sel = i_rx_selftest_field;
    s_d.loop_hit = 1'b0;
    if (!bist_on) begin
      s_d.bist_st = rx_mon_pkg::BIST_OFF;
    end else if (!i_pll_locked) begin
      s_d.bist_st = rx_mon_pkg::BIST_START;
      s_d.diff    = '0;
    end else if (accept) begin
      unique case (s_q.bist_st)
        rx_mon_pkg::BIST_OFF, rx_mon_pkg::BIST_START: begin
          s_d.bist_st  = rx_mon_pkg::BIST_WAIT;
          lfsr_restart = 1'b1;
          s_d.diff     = '0;
        end
        rx_mon_pkg::BIST_WAIT: begin
          if (match) begin
            s_d.bist_st  = rx_mon_pkg::BIST_CMP;
            lfsr_advance = 1'b1;
            s_d.diff     = '0;
            s_d.loop_err = 1'b0;
            code         = `CODE_GOOD;
          end
        end
        rx_mon_pkg::BIST_CMP: begin
          lfsr_advance = 1'b1;
          if (match) begin
            code = `CODE_GOOD;
            if (s_q.diff != 5'h00) begin
              s_d.diff = s_q.diff - 5'h01;
            end
          end else begin
            code         = `CODE_ERR;
            s_d.diff     = s_q.diff + 5'h01;
            s_d.loop_err = 1'b1;
          end
          if (lfsr_at_seed) begin
            code         = (s_q.loop_err || !match) ? `CODE_LOOP_ERR : `CODE_LOOP_OK;
            s_d.loop_err = 1'b0;
            s_d.loop_hit = 1'b1;
          end
          if (s_d.diff == `BIST_ABORT_DIFF) begin
            s_d.bist_st  = rx_mon_pkg::BIST_WAIT;
            lfsr_restart = 1'b1;
            lfsr_advance = 1'b0;
            s_d.diff     = '0;
          end
        end
      endcase
    end

    // Status bus order is status bit, data bit 0, data bit 1.
    if (bist_on) begin
      out_word = {code[2], i_rx_char[9:2], code[0], code[1]};
    end else begin
      out_word = {1'b0, i_rx_char};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q          <= '0;
      s_q.bist_sel <= `BIST_SEL_RESET;
      s_q.last_bit <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  rx_bist_lfsr u_lfsr (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_restart  (lfsr_restart),
    .i_advance  (lfsr_advance),
    .o_char     (lfsr_char),
    .o_at_seed  (lfsr_at_seed)
  );

  // A stall from the host backs up into the deserializer through o_rx_char_ready.
  rx_skid_buffer u_buf (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_valid    (i_rx_char_valid),
    .i_data     (out_word),
    .o_ready    (buf_ready),
    .o_valid    (o_out_valid),
    .o_data     ({o_selftest_status_bit, o_rx_data}),
    .i_ready    (i_out_ready)
  );

  assign o_rx_char_ready      = buf_ready;
  assign o_link_fault_n       = s_q.link_ok;
  assign o_vco_force_training = s_q.force_trn;
  assign o_pll_enable         = s_q.pll_en;
  assign o_reclock_drv1_en    = s_q.drv1;
  assign o_reclock_drv2_en    = s_q.drv2;
  assign o_reclock_logic_en   = s_q.reclk_en;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_chan_off;
    !i_rx_channel_power_enable;
  endsequence

  sequence s_window_end;
    s_q.en && i_rx_channel_power_enable && (s_q.rc_cnt == `RC_LAST_CYC);
  endsequence

  channel_off_fault_a: assert property (s_chan_off |=> !o_link_fault_n && !o_pll_enable)
    else $error("disabled channel did not report link fault");
  force_fault_a: assert property (o_vco_force_training |-> !o_link_fault_n)
    else $error("link fault high while VCO forced");
  force_window_a: assert property ($changed(o_vco_force_training) && s_q.en |-> $past(s_q.rc_cnt) == `RC_LAST_CYC)
    else $error("VCO force changed away from window end");
  window_wrap_a: assert property (s_window_end |=> s_q.rc_cnt == 12'h000)
    else $error("interval counter did not wrap after 4096 cycles");
  // The enable edge itself restarts the count, so counting resumes one cycle later.
  reenable_restart_a: assert property ($rose(i_rx_channel_power_enable) |=> s_q.rc_cnt == 12'h000 ##1 s_q.rc_cnt == 12'h001)
    else $error("interval counter not restarted on enable");
  // Checked on the first edge after release, since the default disable hides the reset cycles themselves.
  drivers_reset_a: assert property (@(posedge i_core_clk) $rose(i_rst_b) |-> !o_reclock_drv1_en && !o_reclock_drv2_en)
    else $error("serial driver enabled during reset");
  reclock_power_a: assert property (o_reclock_logic_en == (o_reclock_drv1_en || o_reclock_drv2_en))
    else $error("reclocker logic enable disagrees with drivers");
  lock_loss_start_a: assert property (bist_on && !i_pll_locked |=> s_q.bist_st == rx_mon_pkg::BIST_START)
    else $error("loss of lock did not restart the checker");
  error_abort_a: assert property (s_q.bist_st == rx_mon_pkg::BIST_CMP && accept && !match && s_q.diff == 5'h0F
                                  && bist_on && i_pll_locked |=> s_q.bist_st == rx_mon_pkg::BIST_WAIT)
    else $error("checker did not abort at 16 excess errors");
  loop_once_a: assert property (s_q.loop_hit |=> !s_q.loop_hit)
    else $error("loop completion shown for more than one character");
  no_transition_a: assert property (s_d.run_cnt == `RUN_LIMIT |=> !o_link_fault_n)
    else $error("long run without transitions kept link good");
  selftest_reset_a: assert property ($rose(i_rst_b) |-> s_q.bist_st == rx_mon_pkg::BIST_OFF)
    else $error("self-test not disabled after reset");
  force_set_a: assert property (s_window_end ##0 (dev_cnt > tol_cnt) |=> o_vco_force_training)
    else $error("VCO not forced after an out-of-range window");
  force_release_a: assert property (s_window_end ##0 (dev_cnt <= tol_cnt && !reserved_cfg)
                                    |=> !o_vco_force_training)
    else $error("VCO still forced after an in-range window");
  reserved_fault_a: assert property (reserved_cfg |=> !o_link_fault_n)
    else $error("reserved speed and rate setting kept link good");
  lock_fault_a: assert property (!i_pll_locked |=> !o_link_fault_n)
    else $error("link good reported without lock");
  pll_follow_a: assert property (i_rx_channel_power_enable |=> o_pll_enable)
    else $error("enabled channel left the PLL off");
  drv_follow_a: assert property (i_reclock_drv1_enable && i_reclock_drv2_enable
                                 |=> o_reclock_drv1_en && o_reclock_drv2_en)
    else $error("requested serial drivers not enabled");
  sync_enter_a: assert property (bist_on && i_pll_locked && accept && match
                                 && s_q.bist_st == rx_mon_pkg::BIST_WAIT |=> s_q.bist_st == rx_mon_pkg::BIST_CMP)
    else $error("checker did not synchronise on the sequence start");
endmodule // rx_range_monitor_bist_checker
`default_nettype wire

// ### rx_far_side_model.sv
// Far-side model: remote self-test transmitter, training clock source and host sink.
`timescale 1ns/1ps
`default_nettype none
module rx_far_side_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_char_ready,
  input  wire logic [1:0] i_tick_mode,
  input  wire logic       i_flat,
  input  wire logic       i_corrupt,
  input  wire logic       i_stall,
  output logic [9:0]      o_char,
  output logic            o_char_valid,
  output logic            o_tick,
  output logic            o_out_ready
);
  logic [8:0] lfsr_q;
  logic [8:0] lfsr_n;
  logic [1:0] phase_q;
  logic       pend_q;
  logic       load;
  assign lfsr_n = {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
  assign load   = o_char_valid && i_char_ready;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lfsr_q       <= 9'h1FF;
      o_char       <= 10'h3FF;
      o_char_valid <= 1'b0;
      o_tick       <= 1'b0;
      o_out_ready  <= 1'b0;
      phase_q      <= 2'h0;
      pend_q       <= 1'b0;
    end else begin
      phase_q      <= phase_q + 2'h1;
      // A tick every character at full rate, every second one at half rate.
      o_tick       <= (i_tick_mode == 2'h0) || ((i_tick_mode == 2'h1) && phase_q[0]);
      // The host drops ready one cycle in four, so words pile up in the buffer.
      o_out_ready  <= !(i_stall && (phase_q == 2'h3));
      o_char_valid <= 1'b1;
      pend_q       <= (pend_q || i_corrupt) && !load;
      if (load) begin
        lfsr_q <= lfsr_n;
        o_char <= i_flat ? 10'h000 : ({^lfsr_n, lfsr_n} ^ {7'h00, pend_q || i_corrupt, 2'h0});
      end
    end
  end
endmodule  // rx_far_side_model
`default_nettype wire

// ### rx_range_monitor_bist_checker_tb_top.sv
// Self-checking bench of the receive range monitor and self-test checker.
`timescale 1ns/1ps
`default_nettype none
module rx_range_monitor_bist_checker_tb_top;
  logic       i_core_clk = 1'b0;
  logic       i_rst_b    = 1'b0;
  logic       en         = 1'b0;
  logic [1:0] spd        = 2'h2;
  logic       rate       = 1'b0;
  logic       lock       = 1'b1;
  logic [1:0] fld        = 2'h0;
  logic [1:0] drv        = 2'h3;
  logic [1:0] tmode      = 2'h0;
  logic       flat       = 1'b0;
  logic       bad        = 1'b0;
  logic       full_chk   = 1'b1;
  logic       tick, cvalid, cready, oready, ovalid, status, lfn, force_t, pll_en, e1, e2, el;
  logic [9:0] ch, od;
  logic [9:0] sent[$];
  int         error_cnt   = 0;
  int         checks_done = 0;
  int         refusals    = 0;
  int         codes[8];
  int         n;
  always #5 i_core_clk = ~i_core_clk;
  rx_range_monitor_bist_checker DUT (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_rx_channel_power_enable(en), .i_rx_speed_select(spd),
    .i_training_rate_select(rate), .i_training_clock_tick(tick), .i_pll_locked(lock),
    .i_rx_selftest_field(fld), .i_reclock_drv1_enable(drv[0]), .i_reclock_drv2_enable(drv[1]),
    .i_rx_char(ch), .i_rx_char_valid(cvalid), .i_out_ready(oready), .o_rx_char_ready(cready),
    .o_out_valid(ovalid), .o_rx_data(od), .o_selftest_status_bit(status), .o_link_fault_n(lfn),
    .o_vco_force_training(force_t), .o_pll_enable(pll_en), .o_reclock_drv1_en(e1),
    .o_reclock_drv2_en(e2), .o_reclock_logic_en(el));
  rx_far_side_model far (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_char_ready(cready), .i_tick_mode(tmode),
    .i_flat(flat), .i_corrupt(bad), .i_stall(1'b1), .o_char(ch), .o_char_valid(cvalid),
    .o_tick(tick), .o_out_ready(oready));
  // Every word leaving the buffer is matched against the characters taken, in order.
  always @(posedge i_core_clk) begin
    if (i_rst_b && !cready) refusals++;
    if (ovalid && oready) begin
      if (fld == 2'h2) codes[{status, od[0], od[1]}]++;
      chk("out_word", {sent[0][9:2], full_chk ? sent[0][1:0] : od[1:0]}, od);
      if (full_chk) chk1("status_bit", 1'b0, status);
      void'(sent.pop_front());
    end
    if (cvalid && cready) sent.push_back(ch);
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask
  task automatic chk(input string w, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, {9'h000, e}, {9'h000, g});
  endtask
  task automatic chk_in(input string w, input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("Error %s expected %0d to %0d seen %0d", w, lo, hi, v);
    end
  endtask
  task automatic wait_sig(input bit sel, input logic v, input int lim);
    n = 0;
    while (((sel ? force_t : lfn) !== v) && (n < lim)) begin
      cyc(1);
      #1;
      n++;
    end
  endtask
  task automatic run(input int k);
    cyc(1);
    #1;
    codes = '{default: 0};
    cyc(k);
    #1;
  endtask
  task automatic t_lock(input string name);
    cyc(1);
    en <= 1'b1;
    // The host ignores the fault output while it settles, so only the settling time is judged.
    wait_sig(1'b0, 1'b1, 4200);
    chk_in("cycles_to_lock", n, 1, 1);
    chk1("pll_enable", 1'b1, pll_en);
    chk1("vco_force", 1'b0, force_t);
    $display("Test %s done", name);
  endtask
  task automatic range_step(input logic [1:0] tm, input logic r, input logic [1:0] s, input logic f);
    cyc(1);
    tmode <= tm;
    rate  <= r;
    spd   <= s;
    wait_sig(1'b1, f, 8400);
    chk_in("cycles_to_force_change", n, 1, 8300);
    chk1("link_fault_n", !f, lfn);
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    $display("Error watchdog expired");
    end_of_test();
  end
  initial begin
    cyc(11);
    #1;
    chk1("drivers_in_reset", 1'b0, e1 | e2 | el);
    chk1("status_in_reset", 1'b0, status);
    cyc(1);
    i_rst_b <= 1'b1;
    cyc(20);
    #1;
    chk1("fault_while_off", 1'b0, lfn);
    chk1("pll_while_off", 1'b0, pll_en);
    t_lock("first_lock");
    cyc(1);
    en <= 1'b0;
    cyc(100);
    #1;
    chk1("fault_after_disable", 1'b0, lfn);
    t_lock("relock");
    range_step(2'h2, 1'b0, 2'h2, 1'b1);
    range_step(2'h1, 1'b1, 2'h1, 1'b0);
    range_step(2'h1, 1'b1, 2'h0, 1'b1);
    range_step(2'h0, 1'b0, 2'h0, 1'b0);
    $display("Test range done");
    cyc(1);
    flat <= 1'b1;
    wait_sig(1'b0, 1'b0, 60);
    chk_in("cycles_to_flat_fault", n, 8, 40);
    cyc(1);
    flat <= 1'b0;
    wait_sig(1'b0, 1'b1, 60);
    chk1("fault_clears", 1'b1, lfn);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      drv <= i[1:0];
      cyc(2);
      #1;
      chk1("drv1_en", i[0], e1);
      chk1("drv2_en", i[1], e2);
      chk1("reclock_logic_en", i != 0, el);
    end
    $display("Test flat_and_drivers done");
    cyc(1);
    fld      <= 2'h2;
    full_chk <= 1'b0;
    cyc(5);
    run(2200);
    chk_in("error_codes", codes[1] + codes[4], 0, 0);
    chk_in("loop_ok_codes", codes[2], 2, 3);
    chk_in("buffer_refusals", refusals, 1, 100000);
    cyc(1);
    bad <= 1'b1;
    cyc(1);
    bad <= 1'b0;
    run(1100);
    chk_in("single_error", codes[1], 1, 1);
    chk_in("loop_err_codes", codes[4], 1, 1);
    cyc(1);
    bad <= 1'b1;
    run(100);
    chk_in("errors_before_abort", codes[1], 15, 17);
    chk_in("wait_codes", codes[3], 1, 1000);
    cyc(1);
    bad <= 1'b0;
    run(1200);
    chk_in("matches_after_resync", codes[0], 100, 1000);
    $display("Test selftest done");
    cyc(1);
    // A port switch shows up here as a loss of lock that the PLL must recover from.
    lock <= 1'b0;
    run(30);
    chk1("fault_on_lock_loss", 1'b0, lfn);
    cyc(1);
    lock <= 1'b1;
    cyc(800);
    #1;
    chk_in("restart_codes", codes[3], 1, 1000);
    chk_in("errors_after_relock", codes[1], 0, 0);
    $display("Test lock_loss done");
    end_of_test();
  end
endmodule  // rx_range_monitor_bist_checker_tb_top
`default_nettype wire
